// >>> hw/uart_ctl_pkg.sv
// Constants and types for the serial channel control block
// Function
// - Transmit FIFO reset clears level, self-clearing
// - DMA select changes ready pin behaviour
// - Transmit request below trigger or empty
// - Transmit trigger bits need enhanced enable
// - Receive request when count crosses trigger
// - One table select serves both directions
// - Tables A and B trigger levels
// - Table C levels, table D programmable
// - Word length five to eight bits
// - Stop bits one, one and a half, or two
// - Parity enable generates and checks parity
// - Even/odd select, odd by default
// - Forced parity mark or space
// - Break holds serial output low
// - Divisor access steers register map
// - Terminal-ready bit drives active-low pin
// - Request-to-send pin, auto and half-duplex
// - First aux bit feeds ring in loopback
// - Second aux pin, carrier in loopback
// - Loopback enable bit
// - FIFO enable must accompany other bits
// - Loopback clear-to-send follows request-to-send
package uart_ctl_pkg;

  localparam int ADDR_W          = 4;
  localparam int LVL_W           = 7;
  localparam int FIFO_DEPTH_DFLT = 64;

  localparam logic [3:0] OFF_DATA       = 4'h0;
  localparam logic [3:0] OFF_DIV_HIGH   = 4'h1;
  localparam logic [3:0] OFF_FIFO_CTL   = 4'h2;
  localparam logic [3:0] OFF_LINE       = 4'h3;
  localparam logic [3:0] OFF_MODEM_CTL  = 4'h4;
  localparam logic [3:0] OFF_DIV_FRAC   = 4'h5;
  localparam logic [3:0] OFF_MODEM_STAT = 4'h6;
  localparam logic [3:0] OFF_ENH        = 4'h7;
  localparam logic [3:0] OFF_AUX        = 4'h8;
  localparam logic [3:0] OFF_ALT        = 4'h9;
  localparam logic [3:0] OFF_TRIG       = 4'hA;
  localparam logic [3:0] OFF_TX_LEVEL   = 4'hB;
  localparam logic [3:0] OFF_RX_LEVEL   = 4'hC;

  localparam int FC_EN     = 0;
  localparam int FC_TX_RST = 2;
  localparam int FC_DMA    = 3;
  localparam int FC_TXT_LO = 4;
  localparam int FC_RXT_LO = 6;
  localparam int LF_STOP   = 2;
  localparam int LF_PAR_EN = 3;
  localparam int LF_EVEN   = 4;
  localparam int LF_FORCE  = 5;
  localparam int LF_BREAK  = 6;
  localparam int LF_DIV    = 7;
  localparam int MC_TERM   = 0;
  localparam int MC_RTS    = 1;
  localparam int MC_AUX1   = 2;
  localparam int MC_AUX2   = 3;
  localparam int MC_LOOP   = 4;
  localparam int EF_ENH    = 4;
  localparam int EF_AUTO   = 6;
  localparam int FA_HALF   = 3;
  localparam int FA_TBL_LO = 4;
  localparam int FA_TRG_TX = 7;
  localparam int AF_PIN_LO = 1;

  localparam logic [7:0]       RST_BYTE   = 8'h00;
  localparam logic [LVL_W-1:0] RST_TRIG   = 7'h01;
  localparam logic [3:0]       MIN_BITS   = 4'h5;
  localparam logic [2:0]       STOP_ONE   = 3'h2;
  localparam logic [2:0]       STOP_ONE_H = 3'h3;
  localparam logic [2:0]       STOP_TWO   = 3'h4;

  // Index 0 at the right
  localparam logic [3:0][LVL_W-1:0] RX_TBL_A = {7'h0E, 7'h08, 7'h04, 7'h01};
  localparam logic [3:0][LVL_W-1:0] RX_TBL_B = {7'h1C, 7'h18, 7'h10, 7'h08};
  localparam logic [3:0][LVL_W-1:0] TX_TBL_B = {7'h1E, 7'h18, 7'h08, 7'h10};
  localparam logic [3:0][LVL_W-1:0] RX_TBL_C = {7'h3C, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][LVL_W-1:0] TX_TBL_C = {7'h38, 7'h20, 7'h10, 7'h08};
  localparam logic [LVL_W-1:0]      TX_TRG_A = 7'h01;

  typedef enum logic [1:0] {
    PAR_ODD   = 2'h0,
    PAR_EVEN  = 2'h1,
    PAR_MARK  = 2'h2,
    PAR_SPACE = 2'h3
  } parity_mode_t;

  typedef struct packed {
    logic [3:0]   data_bits;
    logic [2:0]   stop_halves;
    logic         parity_en;
    parity_mode_t parity;
    logic         brk;
  } frame_cfg_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] frac;
  } divisor_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : uart_ctl_pkg

// >>> hw/uart_line_fifo_modem_control.sv
// Line format, FIFO trigger and modem pin control for one serial channel
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module uart_line_fifo_modem_control
  import uart_ctl_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DFLT
) (
  // Clock and reset
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  // Register port
  input  wire reg_req_t        i_reg,
  output logic [7:0]           o_rd_data,
  // FIFO side
  input  wire logic [7:0]      i_rx_data,
  input  wire logic            i_rx_push,
  input  wire logic            i_tx_pop,
  output logic                 o_rx_pop,
  output logic                 o_tx_push,
  output logic [7:0]           o_tx_data,
  output logic                 o_tx_fifo_reset,
  output logic                 o_fifo_enable,
  output logic [LVL_W-1:0]     o_tx_level,
  output logic [LVL_W-1:0]     o_rx_level,
  output logic                 o_tx_int_req,
  output logic                 o_rx_int_req,
  output logic                 o_tx_ready_n,
  output logic                 o_rx_ready_n,
  // Serial engine side
  input  wire logic            i_tx_serial,
  input  wire logic            i_tx_busy,
  input  wire logic [7:0]      i_tx_char,
  input  wire logic [7:0]      i_rx_char,
  input  wire logic            i_rx_par_bit,
  input  wire logic            i_rx_check,
  output frame_cfg_t           o_frame,
  output divisor_t             o_divisor,
  output logic                 o_tx_parity,
  output logic                 o_rx_parity_err,
  output logic                 o_loopback,
  // Line and modem pins
  input  wire modem_in_t       i_modem_n,
  output logic                 o_txd,
  output logic                 o_term_ready_n,
  output logic                 o_rts_n,
  output logic                 o_aux_two_n,
  output modem_in_t            o_modem_stat
);

  localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(FIFO_DEPTH);

  if (FIFO_DEPTH < 64 || FIFO_DEPTH > 127) begin : g_depth_check
    $error("FIFO_DEPTH must lie in 64 to 127");
  end

  typedef struct packed {
    logic             fifo_en;
    logic             dma;
    logic [1:0]       rx_code;
    logic [1:0]       tx_code;
    logic [7:0]       line;
    logic [7:0]       modem;
    logic [7:0]       enh;
    logic [7:0]       aux;
    logic [7:0]       alt;
    logic [LVL_W-1:0] prog_rx;
    logic [LVL_W-1:0] prog_tx;
    divisor_t         div;
    logic [LVL_W-1:0] tx_cnt;
    logic [LVL_W-1:0] rx_cnt;
    logic             tx_pend;
    logic             tx_filled;
    logic             tx_push;
    logic [7:0]       tx_data;
    logic             tx_rst;
    logic [7:0]       rdata;
    logic             tx_par;
    logic             rx_err;
    modem_in_t        s1;
    modem_in_t        s2;
    modem_in_t        s3;
    modem_in_t        filt;
  } state_t;

  state_t st;
  state_t next_st;

  logic             dlab;
  logic             loop;
  logic [1:0]       table_sel;
  logic [LVL_W-1:0] rx_trig;
  logic [LVL_W-1:0] tx_trig;
  logic             wr_data;
  logic             rd_data;
  modem_in_t        stat;

  // Parity bit for a character of the given length
  function automatic logic par_bit(input logic [7:0] ch, input frame_cfg_t f);
    logic [7:0] mask;
    logic       ones;
    mask = 8'hFF >> (4'h8 - f.data_bits);
    ones = ^(ch & mask);
    unique case (f.parity)
      PAR_ODD:   par_bit = ~ones;
      PAR_EVEN:  par_bit = ones;
      PAR_MARK:  par_bit = 1'b1;
      PAR_SPACE: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  assign dlab      = st.line[LF_DIV];
  assign loop      = st.modem[MC_LOOP];
  assign table_sel = st.aux[FA_TBL_LO +: 2];

  // Both directions read the same table select, so the last write governs both
  always_comb begin
    rx_trig = RX_TBL_A[st.rx_code];
    tx_trig = TX_TRG_A;
    unique case (table_sel)
      2'h0: begin
        rx_trig = RX_TBL_A[st.rx_code];
        tx_trig = TX_TRG_A;
      end
      2'h1: begin
        rx_trig = RX_TBL_B[st.rx_code];
        tx_trig = TX_TBL_B[st.tx_code];
      end
      2'h2: begin
        rx_trig = RX_TBL_C[st.rx_code];
        tx_trig = TX_TBL_C[st.tx_code];
      end
      2'h3: begin
        rx_trig = st.prog_rx;
        tx_trig = st.prog_tx;
      end
    endcase
  end

  // Divisor access hides the data register at offset 0; offsets 1 and 5 hold only divisor bytes
  assign wr_data = i_reg.wr && i_reg.addr == OFF_DATA && !dlab;
  assign rd_data = i_reg.rd && i_reg.addr == OFF_DATA && !dlab;

  always_comb begin
    stat.cts = loop ? st.modem[MC_RTS] : ~st.filt.cts;
    stat.dsr = loop ? st.modem[MC_TERM] : ~st.filt.dsr;
    stat.ri  = loop ? st.modem[MC_AUX1] : ~st.filt.ri;
    stat.cd  = loop ? st.modem[MC_AUX2] : ~st.filt.cd;
  end

  always_comb begin
    next_st         = st;
    next_st.tx_push = 1'b0;
    next_st.tx_rst  = 1'b0;
    next_st.rdata   = 8'h00;

    // The first stage feeds only the second; a change counts once two and three agree
    next_st.s1   = i_modem_n;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);

    // Level counters; a push into a full FIFO is dropped
    if (wr_data) begin
      next_st.tx_push = 1'b1;
      next_st.tx_data = i_reg.wdata;
      if (st.tx_cnt < DEPTH_L) begin
        next_st.tx_cnt = st.tx_cnt + 7'h01;
      end
    end
    // A pop in the same cycle as a data write is not counted, so the write still adds one
    if (i_tx_pop && st.tx_cnt != 7'h00 && !wr_data) begin
      next_st.tx_cnt = st.tx_cnt - 7'h01;
    end
    if (i_rx_push && !rd_data && st.rx_cnt < DEPTH_L) begin
      next_st.rx_cnt = st.rx_cnt + 7'h01;
    end
    if (rd_data && !i_rx_push && st.rx_cnt != 7'h00) begin
      next_st.rx_cnt = st.rx_cnt - 7'h01;
    end

    if (i_reg.wr) begin
      unique case (i_reg.addr)
        OFF_DATA: begin
          if (dlab) begin
            next_st.div.low = i_reg.wdata;
          end
        end
        OFF_DIV_HIGH: begin
          if (dlab) begin
            next_st.div.high = i_reg.wdata;
          end
        end
        OFF_DIV_FRAC: begin
          if (dlab) begin
            next_st.div.frac = i_reg.wdata;
          end
        end
        OFF_FIFO_CTL: begin
          next_st.fifo_en = i_reg.wdata[FC_EN];
          if (i_reg.wdata[FC_EN]) begin
            next_st.dma     = i_reg.wdata[FC_DMA];
            next_st.rx_code = i_reg.wdata[FC_RXT_LO +: 2];
            if (st.enh[EF_ENH]) begin
              next_st.tx_code = i_reg.wdata[FC_TXT_LO +: 2];
            end
            if (i_reg.wdata[FC_TX_RST]) begin
              // Shift register is outside and keeps its character
              next_st.tx_cnt    = 7'h00;
              next_st.tx_rst    = 1'b1;
              next_st.tx_filled = 1'b0;
            end
          end
        end
        OFF_LINE:      next_st.line  = i_reg.wdata;
        OFF_MODEM_CTL: next_st.modem = i_reg.wdata;
        OFF_ENH:       next_st.enh   = i_reg.wdata;
        OFF_AUX:       next_st.aux   = i_reg.wdata;
        OFF_ALT:       next_st.alt   = i_reg.wdata;
        OFF_TRIG: begin
          if (st.aux[FA_TRG_TX]) begin
            next_st.prog_tx = i_reg.wdata[LVL_W-1:0];
          end else begin
            next_st.prog_rx = i_reg.wdata[LVL_W-1:0];
          end
        end
        default: ;
      endcase
    end

    if (i_reg.rd) begin
      unique case (i_reg.addr)
        OFF_DATA:       next_st.rdata = dlab ? st.div.low : i_rx_data;
        OFF_DIV_HIGH:   next_st.rdata = dlab ? st.div.high : 8'h00;
        OFF_DIV_FRAC:   next_st.rdata = dlab ? st.div.frac : 8'h00;
        OFF_LINE:       next_st.rdata = st.line;
        OFF_MODEM_CTL:  next_st.rdata = st.modem;
        OFF_MODEM_STAT: next_st.rdata = {stat, 4'h0};
        OFF_ENH:        next_st.rdata = st.enh;
        OFF_AUX:        next_st.rdata = st.aux;
        OFF_ALT:        next_st.rdata = st.alt;
        OFF_TRIG:       next_st.rdata = {1'b0, st.aux[FA_TRG_TX] ? st.prog_tx : st.prog_rx};
        OFF_TX_LEVEL:   next_st.rdata = {1'b0, st.tx_cnt};
        OFF_RX_LEVEL:   next_st.rdata = {1'b0, st.rx_cnt};
        default:        next_st.rdata = 8'h00;
      endcase
    end

    // A reload that never passed the trigger still warns when it drains
    if (next_st.tx_cnt > tx_trig) begin
      next_st.tx_filled = 1'b1;
    end else if (next_st.tx_cnt == 7'h00) begin
      next_st.tx_filled = 1'b0;
    end
    if (wr_data) begin
      next_st.tx_pend = 1'b0;
    end
    // Set wins over the clear by a data write in the same cycle
    if ((st.tx_cnt >= tx_trig && next_st.tx_cnt < tx_trig) ||
        (st.tx_cnt != 7'h00 && next_st.tx_cnt == 7'h00 && !st.tx_filled)) begin
      next_st.tx_pend = 1'b1;
    end

    next_st.tx_par = par_bit(i_tx_char, o_frame);
    if (i_rx_check) begin
      next_st.rx_err = o_frame.parity_en && (i_rx_par_bit != par_bit(i_rx_char, o_frame));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st         <= '0;
      st.line    <= RST_BYTE;
      st.modem   <= RST_BYTE;
      st.prog_rx <= RST_TRIG;
      st.prog_tx <= RST_TRIG;
      // Pins idle high, so a reset at rest shows no modem change
      st.s1      <= '1;
      st.s2      <= '1;
      st.s3      <= '1;
      st.filt    <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Frame format shared by transmitter and receiver
  always_comb begin
    o_frame.data_bits = MIN_BITS + {2'h0, st.line[1:0]};
    if (!st.line[LF_STOP]) begin
      o_frame.stop_halves = STOP_ONE;
    end else if (st.line[1:0] == 2'h0) begin
      o_frame.stop_halves = STOP_ONE_H;
    end else begin
      o_frame.stop_halves = STOP_TWO;
    end
    o_frame.parity_en = st.line[LF_PAR_EN];
    o_frame.parity    = parity_mode_t'({st.line[LF_FORCE], st.line[LF_EVEN]});
    o_frame.brk       = st.line[LF_BREAK];
  end

  // Receive request follows the count, so reads below the trigger drop it
  assign o_rd_data       = st.rdata;
  assign o_rx_pop        = rd_data;
  assign o_tx_push       = st.tx_push;
  assign o_tx_data       = st.tx_data;
  assign o_tx_fifo_reset = st.tx_rst;
  assign o_fifo_enable   = st.fifo_en;
  assign o_tx_level      = st.tx_cnt;
  assign o_rx_level      = st.rx_cnt;
  assign o_tx_int_req    = st.tx_pend;
  assign o_rx_int_req    = st.rx_cnt >= rx_trig;
  assign o_divisor       = st.div;
  assign o_tx_parity     = st.tx_par;
  assign o_rx_parity_err = st.rx_err;
  assign o_loopback      = loop;
  assign o_modem_stat    = stat;

  // Normal mode flags single characters; DMA mode asks for blocks
  assign o_tx_ready_n = st.dma ? (st.tx_cnt >= DEPTH_L) : (st.tx_cnt != 7'h00);
  assign o_rx_ready_n = st.dma ? (st.rx_cnt < rx_trig) : (st.rx_cnt == 7'h00);

  // Loopback parks the line high and modem outputs inactive
  assign o_txd = loop ? 1'b1 : (st.line[LF_BREAK] ? 1'b0 : i_tx_serial);

  assign o_term_ready_n = loop | ~st.modem[MC_TERM];

  // Half-duplex steering beats auto flow control, which beats the plain bit
  always_comb begin
    if (loop) begin
      o_rts_n = 1'b1;
    end else if (st.aux[FA_HALF]) begin
      o_rts_n = ~i_tx_busy;
    end else if (st.enh[EF_AUTO]) begin
      o_rts_n = st.rx_cnt >= rx_trig;
    end else begin
      o_rts_n = ~st.modem[MC_RTS];
    end
  end

  assign o_aux_two_n = loop || st.alt[AF_PIN_LO +: 2] != 2'h0 || !st.modem[MC_AUX2];

endmodule : uart_line_fifo_modem_control

// >>> test/uart_line_fifo_modem_control_chk.sv
// Concurrent checks on the ports of the serial channel control block
`timescale 1ns/10ps
module uart_ctl_chk
  import uart_ctl_pkg::*;
(
  // Clock, reset and stimulus
  input wire logic             i_sys_clk,
  input wire logic             i_rst_n,
  input wire reg_req_t         i_reg,
  input wire logic             i_rx_push,
  input wire logic             i_tx_serial,
  // Observed outputs
  input wire logic [7:0]       o_rd_data,
  input wire logic             o_rx_pop,
  input wire logic             o_tx_push,
  input wire logic             o_tx_fifo_reset,
  input wire logic [LVL_W-1:0] o_tx_level,
  input wire logic             o_tx_int_req,
  input wire logic             o_rx_int_req,
  input wire frame_cfg_t       o_frame,
  input wire logic             o_loopback,
  input wire logic             o_txd,
  input wire logic             o_term_ready_n,
  input wire logic             o_rts_n,
  input wire logic             o_aux_two_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  rd_slot_zero_a: assert property (!$past(i_reg.rd) |-> o_rd_data == 8'h00)
    else $error("read data outside its slot");
  tx_push_src_a: assert property (o_tx_push |-> $past(i_reg.wr && i_reg.addr == OFF_DATA))
    else $error("transmit push without data write");
  rx_pop_src_a: assert property (o_rx_pop |-> i_reg.rd && i_reg.addr == OFF_DATA)
    else $error("receive pop without data read");
  fifo_rst_src_a: assert property (o_tx_fifo_reset |-> o_tx_level == '0 &&
    $past(i_reg.wr && i_reg.addr == OFF_FIFO_CTL && i_reg.wdata[FC_TX_RST] && i_reg.wdata[FC_EN]))
    else $error("transmit fifo reset wrong");
  break_low_a: assert property (o_frame.brk && !o_loopback |-> !o_txd)
    else $error("break not holding line low");
  txd_pass_a: assert property (!o_frame.brk && !o_loopback |-> o_txd == i_tx_serial)
    else $error("serial output not following shifter");
  half_stop_a: assert property (o_frame.stop_halves == STOP_ONE_H |->
    o_frame.data_bits == MIN_BITS) else $error("one and a half stop bits on long word");
  loop_quiet_a: assert property (o_loopback |-> o_txd && o_rts_n && o_term_ready_n && o_aux_two_n)
    else $error("pins active in loopback");
  tx_req_cause_a: assert property ($rose(o_tx_int_req) |-> o_tx_level < $past(o_tx_level))
    else $error("transmit request without level drop");
  rx_req_cause_a: assert property ($rose(o_rx_int_req) |-> $past(i_rx_push || i_reg.wr))
    else $error("receive request without cause");

  cover property (o_tx_push);
  cover property (o_tx_fifo_reset);
  cover property (o_frame.brk && !o_txd);
  cover property ($rose(o_tx_int_req));
endmodule : uart_ctl_chk

bind uart_line_fifo_modem_control uart_ctl_chk chk (.i_sys_clk, .i_rst_n, .i_reg, .i_rx_push,
  .i_tx_serial, .o_rd_data, .o_rx_pop, .o_tx_push, .o_tx_fifo_reset, .o_tx_level,
  .o_tx_int_req, .o_rx_int_req, .o_frame, .o_loopback, .o_txd, .o_term_ready_n, .o_rts_n,
  .o_aux_two_n);

// >>> test/tx_engine_model.sv
// Behavioural transmit shifter that drains the transmit FIFO on command
`timescale 1ns/10ps
module tx_engine_model
  import uart_ctl_pkg::*;
(
  // Clock, reset and control
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_drain,
  input  wire logic [LVL_W-1:0] i_level,
  // Shifter side
  output logic                  o_serial,
  output logic                  o_busy,
  output logic                  o_pop,
  output logic [7:0]            o_char
);
  logic [1:0] gap;

  // Three ones in every word length, so parity is known for all formats
  assign o_char = 8'h07;
  assign o_busy = i_drain && i_level != '0;
  // Idles at mark; toggles while shifting so a stuck output shows up
  assign o_serial = !o_busy || gap[0];

  // Four cycles between pops lets the level settle before the next one
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      gap   <= 2'h0;
      o_pop <= 1'b0;
    end else begin
      gap   <= gap + 2'h1;
      o_pop <= o_busy && gap == 2'h3;
    end
  end
endmodule : tx_engine_model

// >>> test/uart_line_fifo_modem_control_tb_top.sv
// Register-level testbench for the serial channel control block
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module uart_line_fifo_modem_control_tb_top;
  import uart_ctl_pkg::*;
  logic i_sys_clk, i_rst_n, i_rx_push, drain, i_tx_serial, i_tx_busy, i_tx_pop, rx_chk, rx_par;
  logic o_rx_pop, o_tx_push, o_tx_fifo_reset, o_fifo_enable, o_tx_int_req, o_rx_int_req;
  logic o_tx_ready_n, o_rx_ready_n, o_tx_parity, o_rx_parity_err, o_loopback, o_txd;
  logic o_term_ready_n, o_rts_n, o_aux_two_n;
  logic [7:0] o_rd_data, o_tx_data, i_tx_char, d;
  logic [LVL_W-1:0] o_tx_level, o_rx_level;
  reg_req_t i_reg;
  modem_in_t i_modem_n, o_modem_stat;
  frame_cfg_t o_frame;
  divisor_t o_divisor;
  int fails, comparisons;

  uart_line_fifo_modem_control uut (.i_sys_clk, .i_rst_n, .i_reg, .o_rd_data,
    .i_rx_data(i_tx_char), .i_rx_push, .i_tx_pop, .o_rx_pop, .o_tx_push, .o_tx_data,
    .o_tx_fifo_reset, .o_fifo_enable, .o_tx_level, .o_rx_level, .o_tx_int_req, .o_rx_int_req,
    .o_tx_ready_n, .o_rx_ready_n, .i_tx_serial, .i_tx_busy, .i_tx_char, .i_rx_char(i_tx_char),
    .i_rx_par_bit(rx_par), .i_rx_check(rx_chk), .o_frame, .o_divisor, .o_tx_parity,
    .o_rx_parity_err, .o_loopback, .i_modem_n, .o_txd, .o_term_ready_n, .o_rts_n,
    .o_aux_two_n, .o_modem_stat);
  tx_engine_model far (.i_sys_clk, .i_rst_n, .i_drain(drain), .i_level(o_tx_level),
    .o_serial(i_tx_serial), .o_busy(i_tx_busy), .o_pop(i_tx_pop), .o_char(i_tx_char));

  task automatic results();
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk) i_reg <= '{a, v, 1'b1, 1'b0};
    @(posedge i_sys_clk) i_reg <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_sys_clk) i_reg <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_sys_clk) i_reg <= '0;
    #1 v = o_rd_data;
  endtask : rd

  task automatic push(input int n);
    repeat (n) begin
      @(posedge i_sys_clk) i_rx_push <= 1'b1;
      @(posedge i_sys_clk) i_rx_push <= 1'b0;
    end
    #1;
  endtask : push

  task automatic wait_tx(input logic [LVL_W-1:0] lvl);
    while (o_tx_level !== lvl) begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask : wait_tx

  // Fill to one below the trigger, step over it, then drain through data reads
  task automatic rx_trig(input logic [7:0] aux, input logic [7:0] fifo_control, input int lvl);
    wr(OFF_AUX, aux);
    wr(OFF_TRIG, 8'(lvl));
    wr(OFF_FIFO_CTL, fifo_control);
    push(lvl - 1);
    `CHK(o_rx_int_req, 1'b0)
    `CHK(o_rx_ready_n, fifo_control[FC_DMA] || lvl == 1)
    `CHK(o_rts_n, 1'b0)
    push(1);
    `CHK(o_rx_int_req, 1'b1)
    `CHK(o_rx_ready_n, 1'b0)
    `CHK(o_rts_n, 1'b1)
    repeat (lvl) rd(OFF_DATA, d);
    `CHK(d, 8'h07)
    `CHK(o_rx_level, 7'h00)
  endtask : rx_trig

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fails++;
    results();
  end

  initial begin
    i_rst_n = 1'b0;
    i_reg = '0;
    i_rx_push = 1'b0;
    drain = 1'b0;
    rx_chk = 1'b0;
    rx_par = 1'b0;
    i_modem_n = 4'hF;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    #1;
    rd(OFF_LINE, d);
    `CHK(d, 8'h00)
    rd(OFF_MODEM_CTL, d);
    `CHK(d, 8'h00)
    rd(OFF_FIFO_CTL, d);
    `CHK(d, 8'h00)
    rd(4'hD, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 64; i++) begin
      wr(OFF_LINE, 8'(i));
      rd(OFF_LINE, d);
      `CHK(d, 8'(i))
      `CHK(o_frame.data_bits, MIN_BITS + 4'(i[1:0]))
      `CHK(o_frame.stop_halves, !i[2] ? STOP_ONE : (i[1:0] == 0 ? STOP_ONE_H : STOP_TWO))
      `CHK(o_frame.parity_en, i[3])
      `CHK(o_frame.parity, i[5:4])
      if (i[3]) `CHK(o_tx_parity, i[5:4] == 1 || i[5:4] == 2)
      // Odd steps send a wrong parity bit; only those with parity on must flag
      @(posedge i_sys_clk) {rx_chk, rx_par} <= {1'b1, (i[5:4] == 1 || i[5:4] == 2) ^ i[0]};
      @(posedge i_sys_clk) rx_chk <= 1'b0;
      #1 `CHK(o_rx_parity_err, i[3] & i[0])
    end
    wr(OFF_LINE, 8'h80);
    wr(OFF_DATA, 8'h12);
    wr(OFF_DIV_HIGH, 8'h34);
    wr(OFF_DIV_FRAC, 8'h56);
    `CHK(o_divisor, 24'h123456)
    `CHK(o_tx_level, 7'h00)
    wr(OFF_LINE, 8'h40);
    `CHK(o_txd, 1'b0)
    wr(OFF_LINE, 8'h00);
    `CHK(o_txd, 1'b1)
    wr(OFF_MODEM_CTL, 8'h0B);
    `CHK({o_term_ready_n, o_rts_n, o_aux_two_n}, 3'h0)
    wr(OFF_ALT, 8'h02);
    `CHK(o_aux_two_n, 1'b1)
    wr(OFF_ALT, 8'h00);
    @(posedge i_sys_clk) i_modem_n <= 4'h7;
    repeat (6) @(posedge i_sys_clk);
    rd(OFF_MODEM_STAT, d);
    `CHK(d, 8'h80)
    wr(OFF_MODEM_CTL, 8'h17);
    `CHK(o_loopback, 1'b1)
    repeat (6) @(posedge i_sys_clk);
    rd(OFF_MODEM_STAT, d);
    `CHK(d, 8'h70)
    wr(OFF_MODEM_CTL, 8'h00);
    `CHK(o_loopback, 1'b0)
    // Auto flow control raises the request-to-send pin at the receive trigger
    wr(OFF_ENH, 8'h40);
    rx_trig(8'h00, 8'hC1, 14);
    rx_trig(8'h10, 8'h41, 16);
    rx_trig(8'h20, 8'h81, 56);
    rx_trig(8'h30, 8'h09, 5);
    // Enhanced enable goes first or the transmit trigger bits are dropped
    wr(OFF_ENH, 8'h10);
    wr(OFF_AUX, 8'h28);
    wr(OFF_FIFO_CTL, 8'h21);
    `CHK(o_tx_ready_n, 1'b0)
    repeat (33) wr(OFF_DATA, 8'hA5);
    `CHK(o_tx_level, 7'h21)
    `CHK(o_tx_data, 8'hA5)
    `CHK(o_tx_ready_n, 1'b1)
    wr(OFF_FIFO_CTL, 8'h29);
    `CHK(o_tx_ready_n, 1'b0)
    @(posedge i_sys_clk) drain <= 1'b1;
    wait_tx(7'h20);
    `CHK(o_tx_int_req, 1'b0)
    `CHK(o_rts_n, 1'b0)
    wait_tx(7'h1F);
    `CHK(o_tx_int_req, 1'b1)
    @(posedge i_sys_clk) drain <= 1'b0;
    rd(OFF_TX_LEVEL, d);
    `CHK(d, 8'h1F)
    wr(OFF_FIFO_CTL, 8'h04);
    `CHK({o_fifo_enable, o_tx_level}, 8'h1F)
    wr(OFF_FIFO_CTL, 8'h05);
    `CHK(o_tx_level, 7'h00)
    results();
  end
endmodule : uart_line_fifo_modem_control_tb_top
